// [gpc_defines.svh]
// Register indices, field positions and reset values for the pin config block
`ifndef GPC_DEFINES_SVH
`define GPC_DEFINES_SVH

`define GPC_IDX_P51      8'h40
`define GPC_IDX_P52      8'h41
`define GPC_IDX_P53      8'h42
`define GPC_IDX_P54      8'h43
`define GPC_IDX_LEVEL    8'h44
`define GPC_BIT_DIR      0
`define GPC_BIT_POL      1
`define GPC_FN_HI        3
`define GPC_FN_LO        2
`define GPC_BIT_OTYPE    7
`define GPC_CFG_WMASK    8'h8F
`define GPC_RST_P51      8'h01
`define GPC_RST_P52      8'h01
`define GPC_RST_P53      8'h01
`define GPC_RST_P54      8'h01
`define GPC_ALT_LATENCY  4

`endif

// [gpc_pkg.sv]
// Types shared by the pin config block
package gpc_pkg;
    typedef enum logic [1:0] {
        GPC_FN_GPIO  = 2'h0,
        GPC_FN_SER   = 2'h1,
        GPC_FN_IRQ   = 2'h2,
        GPC_FN_RSVD  = 2'h3
    } gpc_fn_t;

    typedef enum logic [1:0] {
        GPC_BUS_IDLE = 2'h1,
        GPC_BUS_ACK  = 2'h2
    } gpc_bus_st_t;
endpackage

// [gpc_pin_cell.sv]
// One pin: input synchroniser, polarity and output driver control
`timescale 1ns/1ps
`default_nettype none
`include "gpc_defines.svh"
module gpc_pin_cell
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] cfg,
    input  wire logic       out_val,
    input  wire logic       pad_in,
    output var  logic       pad_out,
    output var  logic       pad_oe,
    output var  logic       level
);
    import gpc_pkg::*;

    logic [1:0] sync_ff;
    logic       level_ff;
    logic       out_ff;
    logic       oe_ff;
    logic       pol_val;
    logic       drive;
    logic       od;

    assign pol_val = out_val ^ cfg[`GPC_BIT_POL];
    // Alternate functions are inputs, so only plain I/O may drive
    // drive only as plain output
    assign drive   = !cfg[`GPC_BIT_DIR] && (cfg[`GPC_FN_HI:`GPC_FN_LO] == GPC_FN_GPIO);
    assign od      = cfg[`GPC_BIT_OTYPE];

    // Two stages before anything reads the pad
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            sync_ff <= 2'h0;
        else
            sync_ff <= {sync_ff[0], pad_in};
    end

    // Polarity applies to the sampled level as well
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            level_ff <= 1'b0;
        else
            level_ff <= sync_ff[1] ^ cfg[`GPC_BIT_POL];
    end

    // Open drain only ever pulls low; a high is left to the pull-up
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_ff <= 1'b0;
            oe_ff  <= 1'b0;
        end
        else
        begin
            out_ff <= od ? 1'b0 : pol_val;
            oe_ff  <= drive && (!od || !pol_val);
        end
    end

    assign pad_out = out_ff;
    assign pad_oe  = oe_ff;
    assign level   = level_ff;
endmodule
`default_nettype wire

// [gpc_wb_slave.sv]
// Classic Wishbone slave front end with one wait state
`timescale 1ns/1ps
`default_nettype none
`include "gpc_defines.svh"
module gpc_wb_slave
#(
    parameter int ADR_W = 10
)
(
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [ADR_W-1:0] wb_adr_i,
    input  wire logic [31:0]      wb_dat_i,
    output var  logic [31:0]      wb_dat_o,
    output var  logic             wb_ack_o,
    input  wire logic [7:0]       rd_data,
    output var  logic [7:0]       reg_idx,
    output var  logic             wr_en,
    output var  logic [7:0]       wr_data
);
    import gpc_pkg::*;

    gpc_bus_st_t st_ff;
    gpc_bus_st_t nxt_st;
    logic [7:0]  dat_ff;
    logic        req;

    assign req     = wb_cyc_i && wb_stb_i;
    assign reg_idx = wb_adr_i[9:2];
    assign wr_data = wb_dat_i[7:0];

    // Answer comes one cycle after the request; ack lasts one cycle
    always_comb
    begin
        case (st_ff)
            GPC_BUS_IDLE: nxt_st = req ? GPC_BUS_ACK : GPC_BUS_IDLE;
            GPC_BUS_ACK:  nxt_st = GPC_BUS_IDLE;
            default:      nxt_st = GPC_BUS_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            st_ff <= GPC_BUS_IDLE;
        else
            st_ff <= nxt_st;
    end

    // Read data captured as the answer is prepared
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            dat_ff <= 8'h00;
        else if (st_ff == GPC_BUS_IDLE && req)
            dat_ff <= rd_data;
    end

    // Write lands on the edge where the master sees ack
    assign wr_en    = (st_ff == GPC_BUS_ACK) && req && wb_we_i && wb_sel_i[0];
    assign wb_ack_o = (st_ff == GPC_BUS_ACK) && req;
    assign wb_dat_o = {24'h000000, dat_ff};
endmodule
`default_nettype wire

// [gpc_top.sv]
// Port group 5 low pin configuration registers with pad and routing logic
//
// Behaviour
// - Config bit 0 is direction: one makes the pin input, zero output.
// - Config bit 1 inverts the pin's logic sense when set.
// - Bits 3:2 pick function; 00 plain I/O, 11 reserved; pin 5.1 IRQ4/carrier.
// - Pin 5.2 function 10 routes IRQ5, 01 routes serial-2 receive data.
// - Config bit 7 set gives open-drain drive, clear gives push-pull.
// - Pin 5.1 and 5.2 configs at 40, 41 are read/write, reset 0x01.
// - Pin 5.3 config at 42 shares the layout; function 10 routes IRQ7.
// - Pin 5.4 config at 43 has the same four fields.
`timescale 1ns/1ps
`default_nettype none
`include "gpc_defines.svh"
module gpc_top
#(
    parameter int ADR_W = 10
)
(
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [ADR_W-1:0] wb_adr_i,
    input  wire logic [31:0]      wb_dat_i,
    output var  logic [31:0]      wb_dat_o,
    output var  logic             wb_ack_o,
    input  wire logic [3:0]       pin_out_data,
    input  wire logic [3:0]       pad_in,
    output var  logic [3:0]       pad_out,
    output var  logic [3:0]       pad_oe,
    output var  logic [3:0]       pin_in_data,
    output var  logic             irq4_req,
    output var  logic             irq5_req,
    output var  logic             irq7_req,
    output var  logic             serial2_carrier_detect,
    output var  logic             serial2_receive_data
);
    import gpc_pkg::*;

    localparam logic [7:0] RST_VAL [4] = '{`GPC_RST_P51, `GPC_RST_P52,
                                           `GPC_RST_P53, `GPC_RST_P54};
    localparam logic [7:0] IDX_VAL [4] = '{`GPC_IDX_P51, `GPC_IDX_P52,
                                           `GPC_IDX_P53, `GPC_IDX_P54};

    logic [7:0] cfg_ff [4];
    logic [3:0] level;
    logic [7:0] reg_idx;
    logic       wr_en;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    logic       irq4_ff;
    logic       irq5_ff;
    logic       irq7_ff;
    logic       dcd_ff;
    logic       rxd_ff;
    gpc_fn_t    fn [4];

    // Bus front end
    gpc_wb_slave #(
        .ADR_W    (ADR_W)
    ) u_bus (
        .clk      (clk),
        .rst_n    (rst_n),
        .wb_cyc_i (wb_cyc_i),
        .wb_stb_i (wb_stb_i),
        .wb_we_i  (wb_we_i),
        .wb_sel_i (wb_sel_i),
        .wb_adr_i (wb_adr_i),
        .wb_dat_i (wb_dat_i),
        .wb_dat_o (wb_dat_o),
        .wb_ack_o (wb_ack_o),
        .rd_data  (rd_data),
        .reg_idx  (reg_idx),
        .wr_en    (wr_en),
        .wr_data  (wr_data)
    );

    // One config register and one pad cell per pin
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_pin
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    cfg_ff[gi] <= RST_VAL[gi];
                else if (wr_en && reg_idx == IDX_VAL[gi])
                    cfg_ff[gi] <= wr_data & `GPC_CFG_WMASK;
            end

            assign fn[gi] = gpc_fn_t'(cfg_ff[gi][`GPC_FN_HI:`GPC_FN_LO]);

            // direction and driver type in the cell
            gpc_pin_cell u_cell (
                .clk     (clk),
                .rst_n   (rst_n),
                .cfg     (cfg_ff[gi]),
                .out_val (pin_out_data[gi]),
                .pad_in  (pad_in[gi]),
                .pad_out (pad_out[gi]),
                .pad_oe  (pad_oe[gi]),
                .level   (level[gi])
            );
        end
    endgenerate

    // Sampled levels go to the data register logic outside
    assign pin_in_data = level;

    // Register read mux; unmapped words read as zero
    always_comb
    begin
        case (reg_idx)
            `GPC_IDX_P51:   rd_data = cfg_ff[0];
            `GPC_IDX_P52:   rd_data = cfg_ff[1];
            `GPC_IDX_P53:   rd_data = cfg_ff[2];
            `GPC_IDX_P54:   rd_data = cfg_ff[3];
            `GPC_IDX_LEVEL: rd_data = {4'h0, level};
            default:        rd_data = 8'h00;
        endcase
    end

    // Interrupt routes are active high and idle low when not selected
    // pin 5.1 to IRQ4
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq4_ff <= 1'b0;
            irq5_ff <= 1'b0;
            irq7_ff <= 1'b0;
        end
        else
        begin
            irq4_ff <= (fn[0] == GPC_FN_IRQ) && level[0];
            irq5_ff <= (fn[1] == GPC_FN_IRQ) && level[1];
            irq7_ff <= (fn[2] == GPC_FN_IRQ) && level[2];
        end
    end

    // Serial inputs idle high so an unrouted line looks quiet to the port
    // pin 5.1 to carrier detect
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dcd_ff <= 1'b1;
            rxd_ff <= 1'b1;
        end
        else
        begin
            dcd_ff <= (fn[0] == GPC_FN_SER) ? level[0] : 1'b1;
            rxd_ff <= (fn[1] == GPC_FN_SER) ? level[1] : 1'b1;
        end
    end

    assign irq4_req               = irq4_ff;
    assign irq5_req               = irq5_ff;
    assign irq7_req               = irq7_ff;
    assign serial2_carrier_detect = dcd_ff;
    assign serial2_receive_data   = rxd_ff;

    // Checks on the design's own outputs and config registers

    sequence s_cfg_write(logic [7:0] idx);
        wr_en && reg_idx == idx;
    endsequence

    sequence s_cfg_held(int p);
        cfg_ff[p] == $past(cfg_ff[p], 4) && cfg_ff[p] == $past(cfg_ff[p], 1);
    endsequence

    a_dir_input_float: assert property (
        @(posedge clk) disable iff (!rst_n)
        $past(cfg_ff[0][`GPC_BIT_DIR]) |-> !pad_oe[0])
        else $error("pin 5.1 drives while set as input");

    a_pol_out_sense: assert property (
        @(posedge clk) disable iff (!rst_n)
        ($past(cfg_ff[1]) == 8'h00) |->
            pad_oe[1] && pad_out[1] == $past(pin_out_data[1]))
        else $error("pin 5.2 push-pull output wrong");

    a_pol_out_invert: assert property (
        @(posedge clk) disable iff (!rst_n)
        ($past(cfg_ff[1]) == 8'h02) |->
            pad_oe[1] && pad_out[1] == !$past(pin_out_data[1]))
        else $error("pin 5.2 inverted output wrong");

    // pin 5.1 routes to IRQ4 after the sync path
    a_irq4_route_lat: assert property (
        @(posedge clk) disable iff (!rst_n)
        (fn[0] == GPC_FN_IRQ) ##0 s_cfg_held(0) |->
            irq4_req == ($past(pad_in[0], 4) ^ cfg_ff[0][`GPC_BIT_POL]))
        else $error("IRQ4 route does not follow pin 5.1");

    // pin 5.2 routes to serial receive data
    a_rxd_route_lat: assert property (
        @(posedge clk) disable iff (!rst_n)
        (fn[1] == GPC_FN_SER) ##0 s_cfg_held(1) |->
            serial2_receive_data == ($past(pad_in[1], 4) ^ cfg_ff[1][`GPC_BIT_POL]))
        else $error("receive data route does not follow pin 5.2");

    // open drain never drives a high
    a_od_no_high: assert property (
        @(posedge clk) disable iff (!rst_n)
        $past(cfg_ff[3][`GPC_BIT_OTYPE]) && pad_oe[3] |-> !pad_out[3])
        else $error("open-drain pin 5.4 drives high");

    a_reset_value_p51: assert property (
        @(posedge clk)
        $rose(rst_n) |-> cfg_ff[0] == 8'h01 && cfg_ff[1] == 8'h01)
        else $error("pin 5.1/5.2 config reset value wrong");

    a_irq7_route_lat: assert property (
        @(posedge clk) disable iff (!rst_n)
        (fn[2] == GPC_FN_IRQ) ##0 s_cfg_held(2) |->
            irq7_req == ($past(pad_in[2], 4) ^ cfg_ff[2][`GPC_BIT_POL]))
        else $error("IRQ7 route does not follow pin 5.3");

    // write to 5.4 lands with reserved bits cleared
    a_p54_write_land: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_cfg_write(`GPC_IDX_P54) |=> cfg_ff[3] == ($past(wr_data) & 8'h8F))
        else $error("pin 5.4 config write lost");

    a_rsvd_read_zero: assert property (
        @(posedge clk) disable iff (!rst_n)
        wb_ack_o && !wb_we_i |-> wb_dat_o[6:4] == 3'h0)
        else $error("reserved bits read nonzero");

    // reserved function code never drives or routes
    a_fn_rsvd_quiet: assert property (
        @(posedge clk) disable iff (!rst_n)
        (fn[0] == GPC_FN_RSVD) [*2] |-> !pad_oe[0] && !irq4_req)
        else $error("reserved function code is active");

    // pin 5.2 routes to IRQ5 after the sync path
    a_irq5_route_lat: assert property (
        @(posedge clk) disable iff (!rst_n)
        (fn[1] == GPC_FN_IRQ) ##0 s_cfg_held(1) |->
            irq5_req == ($past(pad_in[1], 4) ^ cfg_ff[1][`GPC_BIT_POL]))
        else $error("IRQ5 route does not follow pin 5.2");

    // pin 5.1 routes to carrier detect
    a_dcd_route_lat: assert property (
        @(posedge clk) disable iff (!rst_n)
        (fn[0] == GPC_FN_SER) ##0 s_cfg_held(0) |->
            serial2_carrier_detect == ($past(pad_in[0], 4) ^ cfg_ff[0][`GPC_BIT_POL]))
        else $error("carrier detect route does not follow pin 5.1");

    // unselected routes of pin 5.2 stay idle
    a_unrouted_idle: assert property (
        @(posedge clk) disable iff (!rst_n)
        ($past(fn[1]) != GPC_FN_IRQ) && ($past(fn[1]) != GPC_FN_SER) |->
            !irq5_req && serial2_receive_data)
        else $error("pin 5.2 route active while not selected");

    // an alternate function never drives the pad
    a_alt_no_drive: assert property (
        @(posedge clk) disable iff (!rst_n)
        ($past(cfg_ff[1][`GPC_FN_HI:`GPC_FN_LO]) != 2'h0) |-> !pad_oe[1])
        else $error("pin 5.2 drives while an alternate function is set");

    // pin 5.1 write lands with reserved bits cleared
    a_p51_write_land: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_cfg_write(`GPC_IDX_P51) |=> cfg_ff[0] == ($past(wr_data) & 8'h8F))
        else $error("pin 5.1 config write lost");

    // pin 5.2 write lands with reserved bits cleared
    a_p52_write_land: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_cfg_write(`GPC_IDX_P52) |=> cfg_ff[1] == ($past(wr_data) & 8'h8F))
        else $error("pin 5.2 config write lost");

    // pin 5.3 write lands with reserved bits cleared
    a_p53_write_land: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_cfg_write(`GPC_IDX_P53) |=> cfg_ff[2] == ($past(wr_data) & 8'h8F))
        else $error("pin 5.3 config write lost");

    // a write with the low byte lane off changes nothing
    a_lane_off_hold: assert property (
        @(posedge clk) disable iff (!rst_n)
        wb_ack_o && wb_we_i && !wb_sel_i[0] |=> cfg_ff[0] == $past(cfg_ff[0]))
        else $error("write with byte lane off changed pin 5.1 config");

    // the bus answer is a single-cycle pulse
    a_ack_one_cycle: assert property (
        @(posedge clk) disable iff (!rst_n)
        wb_ack_o |=> !wb_ack_o)
        else $error("bus ack held longer than one cycle");
endmodule
`default_nettype wire

// [gpio_group5_pin_config_tb.sv]
// Self-checking bench for the port group 5 pin configuration block
`timescale 1ns/1ps
`default_nettype none
module gpio_group5_pin_config_tb;
    logic        clk;
    logic        rst_n;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [9:0]  adr;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic        ack;
    logic [3:0]  pin_out_data;
    logic [3:0]  pad_in;
    logic [3:0]  pad_out;
    logic [3:0]  pad_oe;
    logic [3:0]  pin_in_data;
    logic        irq4_req;
    logic        irq5_req;
    logic        irq7_req;
    logic        cd2;
    logic        rx2;
    logic [7:0]  cur [4];
    logic [31:0] q;
    logic [7:0]  d;
    int          pin;
    integer      seed = 76;
    int          fails = 0;
    int          cmp_count = 0;

    gpc_top #(.ADR_W(10)) gpc_top_inst (
        .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .pin_out_data(pin_out_data), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe(pad_oe), .pin_in_data(pin_in_data),
        .irq4_req(irq4_req), .irq5_req(irq5_req), .irq7_req(irq7_req),
        .serial2_carrier_detect(cd2), .serial2_receive_data(rx2)
    );

    // 25 MHz clock
    always #20 clk = ~clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task final_report;
        $display("Compares: %0d, mismatches: %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // One classic cycle; ack is sampled at the edge, never assumed, and a
    // slave that never answers is left to the watchdog
    task automatic wb_io(input logic w, input logic [7:0] idx, input logic [7:0] v,
                         input logic [3:0] s, output logic [31:0] r);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= s;
        adr <= {idx, 2'b00};
        wdat <= {24'h000000, v};
        @(posedge clk);
        while (ack !== 1'b1)
            @(posedge clk);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    // Route outputs as {irq4, irq5, irq7, carrier, receive}; routed pins keep polarity 0
    function automatic logic [4:0] route(input logic [3:0] pd);
        logic [1:0] f0;
        logic [1:0] f1;
        f0 = cur[0][3:2];
        f1 = cur[1][3:2];
        return {f0 == 2'h2 && pd[0], f1 == 2'h2 && pd[1], cur[2][3:2] == 2'h2 && pd[2],
                f0 == 2'h1 ? pd[0] : 1'b1, f1 == 2'h1 ? pd[1] : 1'b1};
    endfunction

    // Any alternate or reserved code leaves the pad undriven
    function automatic logic oe_exp(input logic [7:0] c, input logic v);
        if (c[0] || c[3:2] != 2'h0)
            return 1'b0;
        return c[7] ? !(v ^ c[1]) : 1'b1;
    endfunction

    // Random pads and drive data, then all pin outputs against the configs
    task automatic settle_check;
        logic [3:0] pd;
        logic [3:0] po;
        pd = 4'($random(seed));
        po = 4'($random(seed));
        pad_in <= pd;
        pin_out_data <= po;
        repeat (6) @(posedge clk);
        for (int i = 0; i < 4; i++)
        begin
            chk(pad_oe[i], oe_exp(cur[i], po[i]), "drive enable");
            if (pad_oe[i] === 1'b1)
                chk(pad_out[i], cur[i][7] ? 1'b0 : po[i] ^ cur[i][1], "drive value");
            chk(pin_in_data[i], pd[i] ^ cur[i][1], "input level");
        end
        chk({irq4_req, irq5_req, irq7_req, cd2, rx2}, route(pd), "routing");
    endtask

    // Write one config, then check every pin twice with fresh random pads
    task automatic cfg_set(input int p, input logic [7:0] v);
        cur[p] = v & 8'h8F;
        wb_io(1'b1, 8'h40 + 8'(p), v, 4'hF, q);
        settle_check;
        settle_check;
    endtask

    // Watchdog well beyond the expected run length
    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        final_report;
    end

    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        sel = 4'h0;
        adr = 10'h000;
        wdat = 32'h00000000;
        pad_in = 4'h0;
        pin_out_data = 4'h0;
        repeat (16) @(posedge clk);
        chk({pad_oe, irq4_req, irq5_req, irq7_req, cd2, rx2}, 32'h03, "reset pins");
        rst_n <= 1'b1;
        for (int p = 0; p < 4; p++)
        begin
            cur[p] = 8'h01;
            wb_io(1'b0, 8'h40 + 8'(p), 8'h00, 4'hF, q);
            chk(q, 32'h01, "reset value");
        end
        // Unmapped place and a write with the low byte lane off
        wb_io(1'b1, 8'h20, 8'hFF, 4'hF, q);
        wb_io(1'b0, 8'h20, 8'h00, 4'hF, q);
        chk(q, 32'h0, "unmapped read");
        wb_io(1'b1, 8'h40, 8'h80, 4'hE, q);
        wb_io(1'b0, 8'h40, 8'h00, 4'hF, q);
        chk(q, 32'h01, "lane off write");
        // Driven corners: plain output on 5.2 both senses, open drain on 5.4
        cfg_set(1, 8'h00);
        cfg_set(1, 8'h02);
        cfg_set(3, 8'h80);
        cfg_set(3, 8'h82);
        // Every function code on every pin, as input with no inversion
        for (int p = 0; p < 4; p++)
            for (int c = 0; c < 4; c++)
                cfg_set(p, {4'h0, 2'(c), 2'b01});
        // Random configs; reserved bits must never stick
        for (int n = 0; n < 40; n++)
        begin
            pin = $random(seed) & 3;
            d = 8'($random(seed));
            if (d[3:2] != 2'h0)
                d[1] = 1'b0;
            cur[pin] = d & 8'h8F;
            wb_io(1'b1, 8'h40 + 8'(pin), d, 4'hF, q);
            wb_io(1'b0, 8'h40 + 8'(pin), 8'h00, 4'hF, q);
            chk(q, {24'h0, cur[pin]}, "readback");
            settle_check;
        end
        final_report;
    end
endmodule
`default_nettype wire
